// ===== shared/adc_ctrl_defines.vh
// Register map, field positions, reset values and timing counts of the converter control block
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// Register byte offsets
`define OFS_SELECTION 12'h000
`define OFS_CONTROL_STATUS 12'h004
`define OFS_MODE 12'h008
`define OFS_ACTIVE 12'h00c
`define OFS_INT_STATUS 12'h010
`define OFS_INT_MASK 12'h014

// selection_register fields
`define SEL_INPUT_LSB 0
`define SEL_INPUT_MSB 3
`define SEL_LEFT_ADJ 5
`define SEL_REF_LSB 6
`define SEL_REF_MSB 7
`define SEL_RESET 8'h00

// Reference codes
`define REF_EXTERNAL_PIN 2'h0
`define REF_ANALOG_SUPPLY 2'h1
`define REF_RESERVED 2'h2
`define REF_INTERNAL_2V56 2'h3

// converter_control_status fields
`define CTL_ENABLE 7
`define CTL_START 6
`define CTL_AUTO 5
`define CTL_DONE 4
`define CTL_PRESC_LSB 0
`define CTL_PRESC_MSB 2
`define PRESC_RESET 3'h0

// Mode register fields
`define MODE_FREE_RUN 0

// Interrupt status and mask fields
`define INT_DONE 0
`define INT_STARTED 1
`define INT_WIDTH 2

// Input codes at or above this value feed the gain amplifier
`define AMP_INPUT_MIN 4'hc

// CPU sleep mode codes
`define SLEEP_IDLE 3'h0
`define SLEEP_NOISE_RED 3'h1

// Conversion lengths in converter clock cycles
`define CONV_CYCLES_FIRST 5'd25
`define CONV_CYCLES_NORMAL 5'd13

`endif

// ===== core/conv_clock_prescaler.v
// Prescaler that makes the converter clock as a one-cycle tick from core_clk
`timescale 1ns/1ps
module conv_clock_prescaler
(
   // Clock and reset
   input wire core_clk,
   input wire reset_n,
   // Control
   input wire restart,
   input wire [2:0] div_select,
   // Converter clock rising edge
   output reg tick
);
   reg [6:0] count_reg;
   wire [6:0] limit;

   // Division by two to the power div_select; zero also divides by two
   assign limit = (div_select == 3'h0) ? 7'h01 : ((7'h01 << div_select) - 7'h01);

   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_reg <= 7'h00;
         tick <= 1'b0;
      end
      else if (restart)
      begin
         // Held in reset while disabled, restarted on a trigger for a fixed delay
         count_reg <= 7'h00;
         tick <= 1'b0;
      end
      else if (count_reg >= limit)
      begin
         count_reg <= 7'h00;
         tick <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + 7'h01;
         tick <= 1'b0;
      end
   end
endmodule

// ===== core/adc_select_buffer_sleep_ctrl.v
// Converter control: buffered selection, conversion sequencing, sleep start and AHB-Lite registers
//
// Summary of operation
// - Selection writes go to a buffer tracked by the converter while idle.
// - Selection locks at conversion start, tracks again in the last converter cycle.
// - Written start bit begins conversion at the next converter clock rising edge.
// - Selection written in a safe window applies to the next conversion.
// - Free running: conversion already started keeps previous selection after a change.
// - Amplified conversions clear the start bit, ending free running without software.
// - Entering idle or noise-reduction sleep when prepared starts a conversion.
// - Completion interrupt wakes the CPU, also raised if woken earlier.
// - Other sleep modes leave the converter enabled and powered.
// - Reference codes: external pin, analog supply, reserved, internal 2.56 V.
// - First conversion after enable takes 25 cycles, normal ones 13.
// - Start bit reads one while converting, cleared when a single conversion ends.
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
module adc_select_buffer_sleep_ctrl
(
   // Clock and reset
   input wire core_clk,
   input wire reset_n,
   // AHB-Lite slave
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // CPU sleep state, same clock domain
   input wire cpu_sleep,
   input wire [2:0] sleep_mode,
   // External auto trigger pin
   input wire trigger_in,
   // Converter side
   output reg [3:0] active_input_select,
   output reg [1:0] active_reference_select,
   output reg converter_power,
   output reg conversion_busy,
   output reg extended_conversion,
   output reg conversion_done_pulse,
   // Interrupt and wake-up
   output wire irq,
   output wire wake_request
);
   // Bus state
   reg dph_write_reg;
   reg dph_read_reg;
   reg read_wait_reg;
   reg [11:0] dph_addr_reg;
   // Software-visible registers
   reg [7:0] sel_buf_reg;
   reg enable_reg;
   reg auto_reg;
   reg free_run_reg;
   reg [2:0] presc_reg;
   reg [`INT_WIDTH-1:0] int_status_reg;
   reg [`INT_WIDTH-1:0] int_mask_reg;
   // Conversion state
   reg start_req_reg;
   reg first_reg;
   reg [4:0] cycle_reg;
   reg sleep_q_reg;
   reg trig_s1_reg;
   reg trig_s2_reg;
   reg trig_s3_reg;
   reg [31:0] rd_next;

   wire tick;
   wire addr_phase;
   wire wr_sel;
   wire wr_ctl;
   wire wr_mode;
   wire wr_int_status;
   wire wr_int_mask;
   wire [4:0] conv_len;
   wire last_cycle;
   wire amplified;
   wire continue_free;
   wire sw_start;
   wire sleep_start;
   wire trig_edge;
   wire sel_load;
   wire start_now;
   wire start_bit_view;

   assign addr_phase = hsel & htrans[1] & hready;
   assign hreadyout = ~read_wait_reg;
   assign hresp = 1'b0;

   assign wr_sel = dph_write_reg & (dph_addr_reg == `OFS_SELECTION);
   assign wr_ctl = dph_write_reg & (dph_addr_reg == `OFS_CONTROL_STATUS);
   assign wr_mode = dph_write_reg & (dph_addr_reg == `OFS_MODE);
   assign wr_int_status = dph_write_reg & (dph_addr_reg == `OFS_INT_STATUS);
   assign wr_int_mask = dph_write_reg & (dph_addr_reg == `OFS_INT_MASK);

   assign conv_len = first_reg ? `CONV_CYCLES_FIRST : `CONV_CYCLES_NORMAL;
   assign last_cycle = conversion_busy & tick & (cycle_reg == conv_len - 5'd1);
   assign amplified = (active_input_select >= `AMP_INPUT_MIN);
   // Free running restarts at once unless the channel is amplified
   assign continue_free = auto_reg & free_run_reg & ~amplified;
   assign start_bit_view = start_req_reg | conversion_busy;

   // A start write is honoured only when the same write leaves the converter enabled
   assign sw_start = wr_ctl & hwdata[`CTL_START] & hwdata[`CTL_ENABLE];
   // Sleep entry starts a conversion only when software prepared the converter
   assign sleep_start = cpu_sleep & ~sleep_q_reg & enable_reg & ~auto_reg & ~conversion_busy & ~start_req_reg &
      ((sleep_mode == `SLEEP_IDLE) | (sleep_mode == `SLEEP_NOISE_RED));
   // Edges during a conversion are ignored
   assign trig_edge = trig_s2_reg & ~trig_s3_reg & enable_reg & auto_reg & ~free_run_reg & ~conversion_busy;
   assign start_now = tick & start_req_reg & ~conversion_busy;
   // Track the buffer while idle or disabled, and again in the last cycle
   assign sel_load = ~enable_reg | (tick & (~conversion_busy | last_cycle));

   assign irq = |(int_status_reg & int_mask_reg);
   // Any unmasked interrupt, completion or start, is the wake source while the CPU sleeps
   assign wake_request = irq & cpu_sleep;

   conv_clock_prescaler u_prescaler
   (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .restart(~enable_reg | trig_edge),
      .div_select(presc_reg),
      .tick(tick)
   );

   always @*
   begin
      rd_next = 32'h00000000;
      if (dph_addr_reg == `OFS_SELECTION)
         rd_next[7:0] = sel_buf_reg;
      else if (dph_addr_reg == `OFS_CONTROL_STATUS)
      begin
         rd_next[`CTL_ENABLE] = enable_reg;
         rd_next[`CTL_START] = start_bit_view;
         rd_next[`CTL_AUTO] = auto_reg;
         rd_next[`CTL_DONE] = int_status_reg[`INT_DONE];
         rd_next[`CTL_PRESC_MSB:`CTL_PRESC_LSB] = presc_reg;
      end
      else if (dph_addr_reg == `OFS_MODE)
         rd_next[`MODE_FREE_RUN] = free_run_reg;
      else if (dph_addr_reg == `OFS_ACTIVE)
         rd_next[9:0] = {extended_conversion, conversion_busy, active_reference_select, 2'h0, active_input_select};
      else if (dph_addr_reg == `OFS_INT_STATUS)
         rd_next[`INT_WIDTH-1:0] = int_status_reg;
      else if (dph_addr_reg == `OFS_INT_MASK)
         rd_next[`INT_WIDTH-1:0] = int_mask_reg;
      else
         rd_next = 32'h00000000;
   end

   // Bus slave: writes take effect in the data phase, reads add one wait state
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dph_write_reg <= 1'b0;
         dph_read_reg <= 1'b0;
         read_wait_reg <= 1'b0;
         dph_addr_reg <= 12'h000;
         hrdata <= 32'h00000000;
      end
      else
      begin
         if (read_wait_reg)
         begin
            // Data sampled after any write of the previous data phase has landed
            hrdata <= rd_next;
            read_wait_reg <= 1'b0;
            dph_read_reg <= 1'b0;
            dph_write_reg <= 1'b0;
         end
         else
         begin
            dph_write_reg <= addr_phase & hwrite;
            dph_read_reg <= addr_phase & ~hwrite;
            read_wait_reg <= addr_phase & ~hwrite;
            if (addr_phase)
               dph_addr_reg <= {haddr[11:2], 2'h0};
         end
      end
   end

   // Software registers and interrupt flags
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sel_buf_reg <= `SEL_RESET;
         enable_reg <= 1'b0;
         auto_reg <= 1'b0;
         free_run_reg <= 1'b0;
         presc_reg <= `PRESC_RESET;
         int_status_reg <= {`INT_WIDTH{1'b0}};
         int_mask_reg <= {`INT_WIDTH{1'b0}};
         converter_power <= 1'b0;
      end
      else
      begin
         // Any write lands in the buffer; the converter only sees it at safe points
         if (wr_sel)
            sel_buf_reg <= {hwdata[7:5], 1'b0, hwdata[3:0]};
         if (wr_ctl)
         begin
            enable_reg <= hwdata[`CTL_ENABLE];
            auto_reg <= hwdata[`CTL_AUTO];
            presc_reg <= hwdata[`CTL_PRESC_MSB:`CTL_PRESC_LSB];
         end
         if (wr_mode)
            free_run_reg <= hwdata[`MODE_FREE_RUN];
         if (wr_int_mask)
            int_mask_reg <= hwdata[`INT_WIDTH-1:0];
         // Write one clears; a new event in the same cycle wins
         int_status_reg <= (int_status_reg & ~({`INT_WIDTH{wr_int_status}} & hwdata[`INT_WIDTH-1:0]) &
            ~({`INT_WIDTH{wr_ctl & hwdata[`CTL_DONE]}} & 2'h1)) |
            {start_now, last_cycle};
         // Power follows the enable bit only, never the sleep mode
         converter_power <= wr_ctl ? hwdata[`CTL_ENABLE] : enable_reg;
      end
   end

   // Conversion sequencer on converter clock ticks
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         start_req_reg <= 1'b0;
         first_reg <= 1'b1;
         cycle_reg <= 5'd0;
         conversion_busy <= 1'b0;
         conversion_done_pulse <= 1'b0;
         extended_conversion <= 1'b0;
         sleep_q_reg <= 1'b0;
         trig_s1_reg <= 1'b0;
         trig_s2_reg <= 1'b0;
         trig_s3_reg <= 1'b0;
         active_input_select <= 4'h0;
         active_reference_select <= `REF_EXTERNAL_PIN;
      end
      else
      begin
         trig_s1_reg <= trigger_in;
         trig_s2_reg <= trig_s1_reg;
         trig_s3_reg <= trig_s2_reg;
         sleep_q_reg <= cpu_sleep;
         conversion_done_pulse <= last_cycle;
         extended_conversion <= conversion_busy & first_reg;

         if (sel_load)
         begin
            active_input_select <= sel_buf_reg[`SEL_INPUT_MSB:`SEL_INPUT_LSB];
            active_reference_select <= sel_buf_reg[`SEL_REF_MSB:`SEL_REF_LSB];
         end

         if (!enable_reg)
         begin
            // Disabled: abandon work, next enable gives a long first conversion
            conversion_busy <= 1'b0;
            cycle_reg <= 5'd0;
            first_reg <= 1'b1;
            start_req_reg <= 1'b0;
         end
         else
         begin
            if (start_now)
            begin
               conversion_busy <= 1'b1;
               cycle_reg <= 5'd0;
               start_req_reg <= 1'b0;
            end
            else if (last_cycle)
            begin
               first_reg <= 1'b0;
               cycle_reg <= 5'd0;
               // Next conversion locks the selection just loaded in this cycle
               conversion_busy <= continue_free;
            end
            else if (conversion_busy & tick)
               cycle_reg <= cycle_reg + 5'd1;
         end
         // Requests taken after the clears, so a set survives, also on the very write that enables
         if (sw_start | sleep_start | trig_edge)
            start_req_reg <= 1'b1;
         if (wr_ctl & hwdata[`CTL_ENABLE] & ~enable_reg)
            first_reg <= 1'b1;
      end
   end
endmodule

// ===== verif/adc_ctrl_assertions.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module adc_ctrl_checker
(
   // Clock and reset
   input wire core_clk,
   input wire reset_n,
   // Bus
   input wire hsel,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   // Sleep
   input wire cpu_sleep,
   input wire [2:0] sleep_mode,
   // Converter side
   input wire [3:0] active_input_select,
   input wire [1:0] active_reference_select,
   input wire converter_power,
   input wire conversion_busy,
   input wire extended_conversion,
   input wire conversion_done_pulse,
   input wire irq,
   input wire wake_request
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Mid-run reloads only happen on the completing cycle
   a_input_lock: assert property ($changed(active_input_select) && $past(conversion_busy)
      |-> ##[0:1] conversion_done_pulse)
      else $error("Input select moved inside a conversion");
   a_ref_lock: assert property ($changed(active_reference_select) && $past(conversion_busy)
      |-> ##[0:1] conversion_done_pulse)
      else $error("Reference moved inside a conversion");
   a_done_once: assert property (conversion_done_pulse |=> !conversion_done_pulse)
      else $error("Done pulse longer than one cycle");
   a_done_cause: assert property ($rose(conversion_done_pulse)
      |-> $past(conversion_busy) || $past(conversion_busy, 2))
      else $error("Done pulse without a conversion");
   a_wake_level: assert property (wake_request == (irq && cpu_sleep))
      else $error("Wake request not irq during sleep");
   a_power_kept: assert property (cpu_sleep && sleep_mode > 3'h1 && converter_power |=> converter_power)
      else $error("Converter switched off by sleep");
   a_abort_stop: assert property ($fell(converter_power) |-> ##[0:2] !conversion_busy)
      else $error("Conversion kept running after disable");
   a_read_wait: assert property (hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
      else $error("Read wait state wrong");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("Response not OKAY");
   c_first: cover property ($fell(extended_conversion));
   c_done: cover property (conversion_done_pulse && conversion_busy);
   c_wake: cover property ($rose(wake_request));
endmodule
bind adc_select_buffer_sleep_ctrl adc_ctrl_checker chk (.core_clk, .reset_n, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .cpu_sleep, .sleep_mode, .active_input_select, .active_reference_select, .converter_power,
   .conversion_busy, .extended_conversion, .conversion_done_pulse, .irq, .wake_request);

// ===== verif/testbench.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
module testbench;
   localparam int DIV = 2;
   logic core_clk, reset_n, hsel, hwrite, hready, cpu_sleep, trigger_in, x;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize, sleep_mode;
   logic [31:0] hwdata, hrdata, q, s, r;
   wire hreadyout, hresp, converter_power, conversion_busy, extended_conversion;
   wire conversion_done_pulse, irq, wake_request;
   wire [3:0] active_input_select;
   wire [1:0] active_reference_select;
   int failures, n_compared, seed, i, n;
   assign hready = hreadyout;
   adc_select_buffer_sleep_ctrl uut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cpu_sleep(cpu_sleep), .sleep_mode(sleep_mode),
      .trigger_in(trigger_in), .active_input_select(active_input_select),
      .active_reference_select(active_reference_select), .converter_power(converter_power),
      .conversion_busy(conversion_busy), .extended_conversion(extended_conversion),
      .conversion_done_pulse(conversion_done_pulse), .irq(irq), .wake_request(wake_request));
   always #2.5 core_clk = ~core_clk;
   function automatic logic [31:0] sel_word(input logic [1:0] rf, input logic [3:0] in);
      sel_word = {24'h0, rf, 2'b00, in};
   endfunction
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   task run(output int k, output logic e);
      k = 0;
      e = 0;
      while (conversion_busy !== 1'b1) @(posedge core_clk);
      while (conversion_busy === 1'b1)
      begin
         k++;
         e = e | extended_conversion;
         @(posedge core_clk);
      end
      e = e | extended_conversion;
   endtask
   task wait_done;
      while (conversion_done_pulse !== 1'b1) @(posedge core_clk);
      cyc(2);
   endtask
   task report_and_stop;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #100000;
      failures++;
      report_and_stop();
   end
   initial
   begin
      seed = 72848;
      failures = 0;
      n_compared = 0;
      core_clk = 0;
      reset_n = 0;
      {hsel, hwrite, cpu_sleep, trigger_in} = 4'h0;
      haddr = 12'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      sleep_mode = 3'h0;
      hwdata = 32'h0;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      bus(0, 12'h004, 0, q);
      chk("ctrl_reset", q, 32'h0);
      bus(1, 12'h01c, 32'hff, q);
      bus(0, 12'h01c, 0, q);
      chk("unmapped", q, 32'h0);
      for (i = 0; i < 4; i++)
      begin
         r = $random(seed);
         s = sel_word(i[1:0], r[3:0] % 4'hc);
         bus(1, 12'h000, s, q);
         cyc(4);
         chk("act_in", active_input_select, s[3:0]);
         chk("act_ref", active_reference_select, i);
         bus(0, 12'h000, 0, q);
         chk("sel_read", q, s);
         bus(0, 12'h00c, 0, q);
         chk("act_read", q, s);
      end
      $display("test selection done");
      bus(1, 12'h004, 32'h80, q);
      bus(1, 12'h004, 32'hc0, q);
      run(n, x);
      chk("first_len", n, 25 * DIV);
      chk("first_ext", x, 1);
      bus(0, 12'h004, 0, q);
      chk("start_clr", q[7:4], 4'h9);
      bus(1, 12'h004, 32'hd0, q);
      run(n, x);
      chk("norm_len", n, 13 * DIV);
      chk("norm_ext", x, 0);
      $display("test timing done");
      bus(1, 12'h008, 32'h1, q);
      bus(1, 12'h004, 32'he0, q);
      wait_done();
      r = sel_word(2'h1, 4'h2);
      bus(1, 12'h000, r, q);
      bus(0, 12'h004, 0, q);
      chk("start_busy", q[6], 1);
      chk("kept_old", active_input_select, s[3:0]);
      wait_done();
      chk("new_in", active_input_select, r[3:0]);
      chk("new_ref", active_reference_select, r[7:6]);
      bus(1, 12'h004, 32'h80, q);
      while (conversion_busy !== 1'b0) @(posedge core_clk);
      bus(1, 12'h000, sel_word(2'h3, 4'hc), q);
      cyc(4);
      bus(1, 12'h004, 32'he0, q);
      wait_done();
      cyc(2 * DIV);
      chk("amp_stop", conversion_busy, 0);
      bus(0, 12'h004, 0, q);
      chk("amp_start", q[6], 0);
      bus(1, 12'h008, 32'h0, q);
      bus(1, 12'h004, 32'h90, q);
      $display("test free run done");
      // Selection changed with auto trigger off, then two converter cycles into a triggered conversion
      bus(1, 12'h000, sel_word(2'h1, 4'h5), q);
      bus(1, 12'h004, 32'ha0, q);
      trigger_in <= 1'b1;
      while (conversion_busy !== 1'b1) @(posedge core_clk);
      cyc(2 * DIV);
      bus(1, 12'h000, sel_word(2'h3, 4'h6), q);
      chk("trig_old", active_input_select, 4'h5);
      trigger_in <= 1'b0;
      wait_done();
      chk("trig_new", active_input_select, 4'h6);
      chk("trig_ref", active_reference_select, 2'h3);
      // Reference just switched: this result is thrown away
      trigger_in <= 1'b1;
      wait_done();
      bus(1, 12'h004, 32'h90, q);
      $display("test trigger done");
      // Single mode, enabled and idle, interrupt unmasked before sleeping
      bus(1, 12'h010, 32'h3, q);
      bus(1, 12'h014, 32'h1, q);
      chk("irq_clear", irq, 0);
      for (i = 0; i < 2; i++)
      begin
         cpu_sleep <= 1'b1;
         sleep_mode <= i[2:0];
         while (wake_request !== 1'b1) @(posedge core_clk);
         chk("wake_irq", irq, 1);
         cpu_sleep <= 1'b0;
         bus(1, 12'h010, 32'h3, q);
         cyc(1);
         chk("irq_w1c", irq, 0);
      end
      cpu_sleep <= 1'b1;
      cyc(3 * DIV);
      chk("sleep_start", conversion_busy, 1);
      cpu_sleep <= 1'b0;
      wait_done();
      chk("late_irq", irq, 1);
      chk("no_wake", wake_request, 0);
      bus(1, 12'h014, 32'h0, q);
      cyc(1);
      chk("masked", irq, 0);
      bus(0, 12'h010, 0, q);
      chk("status", q[0], 1);
      bus(1, 12'h010, 32'h3, q);
      $display("test sleep done");
      r = $random(seed);
      cpu_sleep <= 1'b1;
      sleep_mode <= 3'h2 + r[2:0] % 3'h6;
      cyc(20);
      chk("other_power", converter_power, 1);
      chk("other_idle", conversion_busy, 0);
      cpu_sleep <= 1'b0;
      // Converter stayed on through that sleep: toggle enable, start in the enabling write
      bus(1, 12'h004, 32'h0, q);
      bus(1, 12'h004, 32'hc0, q);
      run(n, x);
      chk("wake_len", n, 25 * DIV);
      chk("wake_ext", x, 1);
      bus(1, 12'h004, 32'hc0, q);
      while (conversion_busy !== 1'b1) @(posedge core_clk);
      bus(1, 12'h004, 32'h0, q);
      cyc(3);
      chk("abort", {converter_power, conversion_busy}, 0);
      $display("test power done");
      report_and_stop();
   end
endmodule
